// >>> bfp_pkg.sv
package bfp_pkg;
	localparam int CLOCK_MHZ       = 50;
	localparam int WD_PULSE_US     = 64;
	localparam int WD_PULSE_CYCLES = WD_PULSE_US * CLOCK_MHZ;
	localparam int CHOP_OFF_US     = 25;
	localparam int CHOP_OFF_CYCLES = CHOP_OFF_US * CLOCK_MHZ;
	localparam int DEGLITCH_CYCLES = 200;
	localparam int RETRY_CYCLES    = 150000;
	localparam int DRIVE_CYCLES    = 100;
	localparam int WD_BASE_CYCLES  = 500000;
	localparam int WD_DELAY_BITS   = 2;
	localparam int CNT_BITS        = 24;
	localparam logic WD_ENABLE_RESET = 1'b0;
	localparam logic [3:0] WD_READ_ADDR = 4'h0;
	typedef enum logic [2:0] {
		BFP_RUN   = 3'b001,
		BFP_RETRY = 3'b010,
		BFP_HALT  = 3'b100
	} bfp_state_type;
endpackage

// >>> bfp_timer_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bfp_timer_if #(parameter int W = 24);
	logic         start;
	logic [W-1:0] length;
	logic         busy;
	logic         done;
	modport owner (output start, output length, input busy, input done);
	modport timer (input start, input length, output busy, output done);
endinterface
`default_nettype wire

// >>> bfp_timer.sv
`timescale 1ns/100ps
`default_nettype none
module bfp_timer #(
	parameter int W = 24
) (
	input  wire logic clock,
	input  wire logic rstSync_n,
	bfp_timer_if.timer t
);
	import bfp_pkg::*;
	if (W < 2) begin : g_badWidth
		$error("bfp_timer: counter width too small");
	end
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic         done_reg;
	logic         done_next;
	always_comb begin
		count_next = count_reg;
		done_next  = 1'b0;
		if (t.start) begin
			count_next = t.length;
		end else if (count_reg != '0) begin
			count_next = count_reg - 1'b1;
			done_next  = (count_reg == {{(W-1){1'b0}}, 1'b1});
		end
	end
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			count_reg <= '0;
			done_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			done_reg  <= done_next;
		end
	end
	assign t.busy = (count_reg != '0);
	assign t.done = done_reg;
endmodule
`default_nettype wire

// >>> bfp_deglitch.sv
`timescale 1ns/100ps
`default_nettype none
module bfp_deglitch #(
	parameter int N = 4,
	parameter int W = 24
) (
	input  wire logic         clock,
	input  wire logic         rstSync_n,
	input  wire logic [N-1:0] level,
	input  wire logic [W-1:0] limit,
	output var  logic [N-1:0] hit
);
	import bfp_pkg::*;
	if (N < 1 || W < 2) begin : g_badSize
		$error("bfp_deglitch: channel count or width too small");
	end
	for (genvar i = 0; i < N; i++) begin : g_ch
		logic [W-1:0] run_reg;
		logic [W-1:0] run_next;
		always_comb begin
			run_next = '0;
			if (level[i]) begin
				run_next = (run_reg == limit) ? run_reg : run_reg + 1'b1;
			end
		end
		always_ff @(posedge clock or negedge rstSync_n) begin
			if (!rstSync_n) begin
				run_reg <= '0;
			end else begin
				run_reg <= run_next;
			end
		end
		// Continuous level only; any drop restarts count
		assign hit[i] = level[i] && (run_reg == limit);
	end
endmodule
`default_nettype wire

// >>> bfp_fault_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module bfp_fault_ctrl #(
	parameter int DEGLITCH = bfp_pkg::DEGLITCH_CYCLES,
	parameter int RETRY    = bfp_pkg::RETRY_CYCLES,
	parameter int DRIVE    = bfp_pkg::DRIVE_CYCLES,
	parameter int WD_BASE  = bfp_pkg::WD_BASE_CYCLES,
	parameter int WD_PULSE = bfp_pkg::WD_PULSE_CYCLES,
	parameter logic PIN_VARIANT = 1'b0
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       logicSupplyLockout,
	input  wire logic       driverSupplyLockout,
	input  wire logic       pumpUndervoltage,
	input  wire logic [3:0] drainSourceOver,
	input  wire logic [3:0] fetDriven,
	input  wire logic       shuntSensePinOver,
	input  wire logic [3:0] gateCommand,
	input  wire logic [3:0] gateLevel,
	input  wire logic       thermalShutdown,
	input  wire logic       regRead,
	input  wire logic [3:0] regReadAddr,
	input  wire logic       watchdogEnableWrite,
	input  wire logic       watchdogEnableData,
	input  wire logic [bfp_pkg::WD_DELAY_BITS-1:0] watchdogDelayField,
	input  wire logic       clearFaultsBit,
	input  wire logic       chopOffWrite,
	input  wire logic [bfp_pkg::CNT_BITS-1:0] chopOffData,
	output var  logic       gateEnable,
	output var  logic       pumpEnable,
	output var  logic       analogRegulatorEnable,
	output var  logic       fault_out_n,
	output var  logic       watchdog_fault_out_n,
	output var  logic       supply_uv_flag,
	output var  logic       pump_uv_flag,
	output var  logic       overcurrent_flag,
	output var  logic       gate_fault_flag,
	output var  logic       overtemp_flag,
	output var  logic       watchdog_fault_flag,
	output var  logic       watchdog_enable_bit,
	output var  logic       currentRegEnable,
	output var  logic [bfp_pkg::CNT_BITS-1:0] chop_off_time
);
	import bfp_pkg::*;
	localparam int W = CNT_BITS;
	// Counts must fit the shared counter width
	if (RETRY < 1 || RETRY >= 2**W) begin : g_badRetry
		$error("bfp_fault_ctrl: retry count out of range");
	end
	if (DEGLITCH < 1 || DEGLITCH >= 2**W) begin : g_badDeglitch
		$error("bfp_fault_ctrl: deglitch count out of range");
	end
	if (DRIVE < 1 || DRIVE >= 2**W) begin : g_badDrive
		$error("bfp_fault_ctrl: drive window out of range");
	end
	if (WD_PULSE < 1 || WD_PULSE >= 2**W) begin : g_badPulse
		$error("bfp_fault_ctrl: watchdog pulse out of range");
	end
	// Longest interval is the base shifted by three
	if (WD_BASE < 1 || WD_BASE * 8 >= 2**W) begin : g_badBase
		$error("bfp_fault_ctrl: watchdog base out of range");
	end

	// Reset sync; logic lockout also resets everything
	// Two stages keep the release clear of the clock edge
	logic syncA_reg;
	logic syncB_reg;
	logic rstSync_n;
	logic rawRst_n;
	assign rawRst_n = rst_n & ~logicSupplyLockout;
	always_ff @(posedge clock or negedge rawRst_n) begin
		if (!rawRst_n) begin
			syncA_reg <= 1'b0;
			syncB_reg <= 1'b0;
		end else begin
			syncA_reg <= 1'b1;
			syncB_reg <= syncA_reg;
		end
	end
	assign rstSync_n = syncB_reg;

	// Overcurrent deglitch and gate drive window
	logic [3:0] vdsHit;
	logic [3:0] gateMiss;
	logic [3:0] gateHit;
	logic [3:0] vdsLevel;
	logic       gateRun;
	// Only a driven FET can show a real overcurrent
	assign vdsLevel = drainSourceOver & fetDriven;
	bfp_deglitch #(.N(4), .W(W)) u_vds (
		.clock     (clock),
		.rstSync_n (rstSync_n),
		.level     (vdsLevel),
		.limit     (W'(DEGLITCH)),
		.hit       (vdsHit)
	);
	// Window follows the drive request, not gateEnable,
	// which would close a loop through gdEvent
	assign gateMiss = (gateCommand ^ gateLevel) & {4{gateRun}};
	bfp_deglitch #(.N(4), .W(W)) u_gate (
		.clock     (clock),
		.rstSync_n (rstSync_n),
		.level     (gateMiss),
		.limit     (W'(DRIVE)),
		.hit       (gateHit)
	);

	logic ocEvent;
	logic gdEvent;
	assign ocEvent = (|vdsHit) | shuntSensePinOver;
	assign gdEvent = |gateHit;

	// Retry and watchdog timers
	bfp_timer_if #(.W(W)) retryT ();
	bfp_timer_if #(.W(W)) wdT ();
	bfp_timer_if #(.W(W)) pulseT ();
	// One retry timer serves overcurrent and gate faults
	bfp_timer #(.W(W)) u_retry (
		.clock     (clock),
		.rstSync_n (rstSync_n),
		.t         (retryT)
	);
	bfp_timer #(.W(W)) u_wd (
		.clock     (clock),
		.rstSync_n (rstSync_n),
		.t         (wdT)
	);
	bfp_timer #(.W(W)) u_pulse (
		.clock     (clock),
		.rstSync_n (rstSync_n),
		.t         (pulseT)
	);

	bfp_state_type state_reg;
	bfp_state_type state_next;
	logic [5:0] flags_reg;
	logic [5:0] flags_next;
	logic       wdEn_reg;
	logic       wdEn_next;
	logic [W-1:0] chop_reg;
	logic [W-1:0] chop_next;
	logic       wdExpire;
	logic       wdActive_reg;
	logic       wdActive_next;

	assign wdExpire = wdActive_reg && wdT.done;

	always_comb begin
		state_next   = state_reg;
		retryT.start = 1'b0;
		retryT.length = W'(RETRY);
		case (state_reg)
			BFP_RUN: begin
				if (wdExpire) begin
					state_next = BFP_HALT;
				end else if (ocEvent || gdEvent) begin
					state_next   = BFP_RETRY;
					retryT.start = 1'b1;
				end
			end
			BFP_RETRY: begin
				if (wdExpire) begin
					state_next = BFP_HALT;
				end else if (retryT.done) begin
					// Re-enable; a lasting fault trips again
					state_next = BFP_RUN;
				end
			end
			BFP_HALT: begin
				if (clearFaultsBit) begin
					state_next = BFP_RUN;
				end
			end
			default: state_next = BFP_RUN;
		endcase
	end

	// Watchdog: a read of register zero restarts it
	logic wdKick;
	assign wdKick = regRead && (regReadAddr == WD_READ_ADDR);
	always_comb begin
		wdEn_next = wdEn_reg;
		if (watchdogEnableWrite) begin
			wdEn_next = watchdogEnableData;
		end
		if (wdExpire) begin
			wdEn_next = 1'b0;
		end
		wdActive_next = wdEn_next;
		wdT.length = W'(WD_BASE) << watchdogDelayField;
		wdT.start  = wdEn_next
		             && (wdKick
		                 || !wdEn_reg
		                 || (!wdT.busy && !wdActive_reg));
		pulseT.start  = wdExpire;
		pulseT.length = W'(WD_PULSE);
	end

	// Sticky flags: set wins over clear
	logic [5:0] flagSet;
	assign flagSet = {wdExpire,
	                  thermalShutdown,
	                  gdEvent,
	                  ocEvent,
	                  pumpUndervoltage,
	                  driverSupplyLockout};
	always_comb begin
		flags_next = clearFaultsBit ? flagSet : (flags_reg | flagSet);
	end

	// Pin variant fixes off time; else it is writable
	always_comb begin
		chop_next = chop_reg;
		if (PIN_VARIANT) begin
			chop_next = W'(CHOP_OFF_CYCLES);
		end else if (chopOffWrite) begin
			chop_next = chopOffData;
		end
	end

	// State register
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_reg <= BFP_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Sticky flag register
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// Watchdog enable register
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			wdEn_reg     <= WD_ENABLE_RESET;
			wdActive_reg <= 1'b0;
		end else begin
			wdEn_reg     <= wdEn_next;
			wdActive_reg <= wdActive_next;
		end
	end

	// Off time register; logic lockout restores default
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			chop_reg <= W'(CHOP_OFF_CYCLES);
		end else begin
			chop_reg <= chop_next;
		end
	end

	// Outputs; lockout and pump faults are live levels
	logic faultAny;
	assign faultAny = driverSupplyLockout
	                | pumpUndervoltage
	                | thermalShutdown
	                | (state_reg != BFP_RUN)
	                | !rstSync_n;
	logic out_reg;
	logic out_next;
	always_comb begin
		out_next = ~faultAny;
	end
	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			out_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
		end
	end
	// Fault output held low through reset and lockout
	assign fault_out_n = out_reg & ~faultAny;
	assign gateRun = rstSync_n
	               & ~driverSupplyLockout
	               & ~pumpUndervoltage
	               & ~thermalShutdown
	               & (state_reg == BFP_RUN)
	               & ~ocEvent
	               & ~wdExpire;
	// Every cause but the gate window is already in gateRun
	assign gateEnable  = gateRun & ~gdEvent;
	assign pumpEnable  = rstSync_n
	                   & ~driverSupplyLockout
	                   & ~thermalShutdown;
	assign analogRegulatorEnable = rstSync_n & ~thermalShutdown;
	assign watchdog_fault_out_n  = ~pulseT.busy;

	assign supply_uv_flag        = flags_reg[0];
	assign pump_uv_flag          = flags_reg[1];
	assign overcurrent_flag      = flags_reg[2];
	assign gate_fault_flag       = flags_reg[3];
	assign overtemp_flag         = flags_reg[4];
	assign watchdog_fault_flag   = flags_reg[5];

	assign watchdog_enable_bit   = wdEn_reg;
	assign currentRegEnable      = 1'b1;
	assign chop_off_time         = chop_reg;
endmodule
`default_nettype wire

// >>> bfp_fault_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module bfp_fault_ctrl_assertions #(
	parameter int WD_PULSE = 3200
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic logicSupplyLockout,
	input wire logic driverSupplyLockout,
	input wire logic pumpUndervoltage,
	input wire logic thermalShutdown,
	input wire logic clearFaultsBit,
	input wire logic gateEnable,
	input wire logic pumpEnable,
	input wire logic analogRegulatorEnable,
	input wire logic fault_out_n,
	input wire logic watchdog_fault_out_n,
	input wire logic supply_uv_flag,
	input wire logic pump_uv_flag,
	input wire logic overtemp_flag,
	input wire logic watchdog_fault_flag,
	input wire logic watchdog_enable_bit
);
	logic [2:0] liveReg;
	int         lowCnt;
	wire logic  anySet = driverSupplyLockout | pumpUndervoltage
		| thermalShutdown;
	// Silent until the two-stage reset release has passed
	always_ff @(posedge clock or negedge rst_n
		or posedge logicSupplyLockout) begin
		if (!rst_n || logicSupplyLockout) liveReg <= 3'h0;
		else liveReg <= {liveReg[1:0], 1'b1};
	end
	always_ff @(posedge clock) begin
		lowCnt <= watchdog_fault_out_n ? 0 : lowCnt + 1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (liveReg != 3'h7);
	property p_uvOff;
		driverSupplyLockout |-> !gateEnable && !pumpEnable && !fault_out_n;
	endproperty
	a_uvOff: assert property (p_uvOff) else $error("uv enables");
	property p_uvFlag;
		driverSupplyLockout |-> ##[1:2] supply_uv_flag;
	endproperty
	a_uvFlag: assert property (p_uvFlag) else $error("uv flag");
	property p_uvSticky;
		supply_uv_flag && !clearFaultsBit |=> supply_uv_flag;
	endproperty
	a_uvSticky: assert property (p_uvSticky) else $error("uv lost");
	property p_pump;
		pumpUndervoltage && !driverSupplyLockout && !thermalShutdown
			|-> pumpEnable && !gateEnable && !fault_out_n;
	endproperty
	a_pump: assert property (p_pump) else $error("pump uv");
	property p_hot;
		thermalShutdown |-> !gateEnable && !pumpEnable
			&& !analogRegulatorEnable && !fault_out_n;
	endproperty
	a_hot: assert property (p_hot) else $error("overtemp");
	property p_clear;
		clearFaultsBit && !anySet && !$past(anySet)
			|=> !(supply_uv_flag || pump_uv_flag || overtemp_flag);
	endproperty
	a_clear: assert property (p_clear) else $error("clear");
	property p_pulse;
		$rose(watchdog_fault_out_n) |-> lowCnt == WD_PULSE;
	endproperty
	a_pulse: assert property (p_pulse) else $error("wd pulse");
	property p_expiry;
		$fell(watchdog_fault_out_n) |-> !watchdog_enable_bit
			&& !gateEnable && !fault_out_n && watchdog_fault_flag;
	endproperty
	a_expiry: assert property (p_expiry) else $error("wd expiry");
	property p_halt;
		watchdog_fault_flag |-> !gateEnable;
	endproperty
	a_halt: assert property (p_halt) else $error("wd halt");
endmodule
bind bfp_fault_ctrl bfp_fault_ctrl_assertions #(.WD_PULSE(WD_PULSE)) u_chk (
	.clock, .rst_n, .logicSupplyLockout, .driverSupplyLockout,
	.pumpUndervoltage, .thermalShutdown, .clearFaultsBit, .gateEnable,
	.pumpEnable, .analogRegulatorEnable, .fault_out_n,
	.watchdog_fault_out_n, .supply_uv_flag, .pump_uv_flag, .overtemp_flag,
	.watchdog_fault_flag, .watchdog_enable_bit);
`default_nettype wire

// >>> bfp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module bfp_host_model #(
	parameter int GAP = 20
) (
	input  wire logic       clock,
	input  wire logic       kickOn,
	output var  logic       regRead,
	output var  logic [3:0] regReadAddr,
	output var  logic       enWrite,
	output var  logic       enData
);
	int   gap;
	logic kickPrev;
	initial begin
		regRead = 1'b0;
		regReadAddr = 4'h5;
		enWrite = 1'b0;
		enData = 1'b1;
		gap = 0;
		kickPrev = 1'b0;
	end
	// Address inverts between kicks; after a kick it alternates 0 and F
	always @(posedge clock) begin
		gap <= (gap == GAP) ? 0 : gap + 1;
		kickPrev <= kickOn;
		enWrite <= kickOn && !kickPrev;
		regRead <= kickOn && gap == GAP;
		regReadAddr <= (kickOn && gap == GAP) ? 4'h0 : ~regReadAddr;
	end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clock, rst_n, logUv, drvUv, pumpUv, hot, shunt, clr, chW, kick;
	logic [3:0] dsOver, gCmd, gLvl, fetOn;
	logic [1:0] wdDly;
	logic [23:0] chD;
	logic regRead, enWrite, enData;
	logic [3:0] rdAddr;
	logic gateEnable, pumpEnable, aEn, fault_out_n, wdOut, svF, pvF, ocF;
	logic gfF, otF, wdF, wdEn, curReg;
	logic [23:0] chop;
	int num_errors = 0, n_tests = 0, cycles = 0, n;
	logic prev;
	wire logic [8:0] st = {gateEnable, pumpEnable, aEn, fault_out_n,
		svF, pvF, ocF, gfF, otF};
	bfp_fault_ctrl #(.DEGLITCH(4), .RETRY(20), .DRIVE(4), .WD_BASE(50))
	u_bfp_fault_ctrl (.clock(clock), .rst_n(rst_n),
		.logicSupplyLockout(logUv), .driverSupplyLockout(drvUv),
		.pumpUndervoltage(pumpUv), .drainSourceOver(dsOver),
		.fetDriven(fetOn), .shuntSensePinOver(shunt), .gateCommand(gCmd),
		.gateLevel(gLvl), .thermalShutdown(hot), .regRead(regRead),
		.regReadAddr(rdAddr), .watchdogEnableWrite(enWrite),
		.watchdogEnableData(enData), .watchdogDelayField(wdDly),
		.clearFaultsBit(clr), .chopOffWrite(chW), .chopOffData(chD),
		.gateEnable(gateEnable), .pumpEnable(pumpEnable),
		.analogRegulatorEnable(aEn), .fault_out_n(fault_out_n),
		.watchdog_fault_out_n(wdOut), .supply_uv_flag(svF),
		.pump_uv_flag(pvF), .overcurrent_flag(ocF), .gate_fault_flag(gfF),
		.overtemp_flag(otF), .watchdog_fault_flag(wdF),
		.watchdog_enable_bit(wdEn), .currentRegEnable(curReg),
		.chop_off_time(chop));
	bfp_host_model u_bfp_host_model (.clock(clock), .kickOn(kick),
		.regRead(regRead), .regReadAddr(rdAddr), .enWrite(enWrite),
		.enData(enData));
	task automatic chk(input logic [31:0] e, input logic [31:0] a);
		n_tests++;
		if (a !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic w(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task automatic clearAll;
		@(posedge clock) clr <= 1'b1;
		@(posedge clock) clr <= 1'b0;
		w(3);
	endtask
	task automatic report_and_stop;
		if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// FETs conduct one cycle after the drive turns on
	always @(posedge clock) fetOn <= {4{gateEnable}};
	// Hang guard, well above the few thousand cycles needed
	initial begin
		forever begin
			@(posedge clock);
			cycles++;
			if (cycles == 20000) begin
				num_errors++;
				report_and_stop;
			end
		end
	end
	initial begin
		{rst_n, logUv, drvUv, pumpUv, hot, shunt, clr, chW, kick} = 9'h0;
		{dsOver, gCmd, gLvl, chD} = 36'h0;
		wdDly = 2'h0;
		w(7);
		@(posedge clock) rst_n <= 1'b1;
		w(4);
		chk(9'h1e0, st);
		chk(3'b001, {wdEn, wdF, wdOut});
		chk({1'b1, 24'h0004e2}, {curReg, chop});
		@(posedge clock) {chW, chD} <= {1'b1, 24'h000abc};
		@(posedge clock) {chW, drvUv, dsOver} <= {2'b01, 4'h4};
		w(6);
		chk(4'b0001, {st[8:7], st[5:4]});
		chk(1'b0, ocF);
		@(posedge clock) {drvUv, dsOver} <= 5'h00;
		w(3);
		chk(3'b111, {st[8], st[5:4]});
		chk(24'h000abc, chop);
		@(posedge clock) pumpUv <= 1'b1;
		w(3);
		chk(4'b0101, {st[8:7], st[5], st[3]});
		@(posedge clock) pumpUv <= 1'b0;
		w(3);
		chk(3'b111, {st[8], st[5], st[3]});
		@(posedge clock) hot <= 1'b1;
		w(3);
		chk(5'b00001, {st[8:5], st[0]});
		@(posedge clock) hot <= 1'b0;
		w(3);
		chk(3'b111, {st[8], st[5], st[0]});
		clearAll;
		chk(9'h1e0, st);
		@(posedge clock) dsOver <= 4'h1;
		repeat (3) @(posedge clock);
		dsOver <= 4'h0;
		w(5);
		chk(1'b0, ocF);
		@(posedge clock) dsOver <= 4'h2;
		w(10);
		chk(3'b001, {st[8], st[5], st[2]});
		n = 0;
		prev = gateEnable;
		repeat (80) begin
			@(posedge clock);
			#1;
			if (gateEnable === 1'b1 && prev === 1'b0) n++;
			prev = gateEnable;
		end
		chk(1'b1, n >= 2);
		@(posedge clock) dsOver <= 4'h0;
		w(30);
		chk(3'b111, {st[8], st[5], st[2]});
		clearAll;
		@(posedge clock) shunt <= 1'b1;
		@(posedge clock) shunt <= 1'b0;
		w(3);
		chk(2'b01, {st[5], st[2]});
		w(30);
		clearAll;
		@(posedge clock) gCmd <= 4'h1;
		w(8);
		chk(3'b001, {st[8], st[5], st[1]});
		@(posedge clock) gLvl <= 4'h1;
		w(30);
		chk(3'b111, {st[8], st[5], st[1]});
		@(posedge clock) logUv <= 1'b1;
		w(2);
		chk(10'h000, {st, wdEn});
		@(posedge clock) logUv <= 1'b0;
		w(5);
		chk({9'h1e0, 24'h0004e2}, {st, chop});
		@(posedge clock) {kick, wdDly} <= 3'b101;
		w(300);
		chk(2'b10, {wdEn, wdF});
		@(posedge clock) kick <= 1'b0;
		w(60);
		chk(2'b10, {wdEn, wdF});
		w(60);
		chk(5'b01000, {wdEn, wdF, st[8], st[5], wdOut});
		w(3300);
		chk(3'b100, {wdOut, st[8], st[5]});
		clearAll;
		chk(3'b011, {wdF, st[8], st[5]});
		report_and_stop;
	end
endmodule
`default_nettype wire
